// [common/bridge_params.svh]
`ifndef BRIDGE_BUS_IO_params_SVH
`define BRIDGE_BUS_IO_params_SVH

// register bus geometry
`define REG_ADDR_W        8
`define REG_DATA_W        32

// register byte offsets
`define OFS_BUS_NUMBERS   8'h18
`define OFS_IO_STATUS     8'h1C
`define OFS_CONTROL       8'h40
`define OFS_IRQ_STATUS    8'h44
`define OFS_IRQ_CLEAR     8'h48
`define OFS_IRQ_ENABLE    8'h4C

// bus number dword fields
`define DS_BUS_LSB        8
`define DS_BUS_MSB        15
`define HB_BUS_LSB        16
`define HB_BUS_MSB        23
`define BUS_NUM_RESET     8'h00
`define LATENCY_VALUE     8'h00

// io window / status dword fields
`define IO_BOT_LSB        4
`define IO_BOT_MSB        7
`define IO_TOP_LSB        12
`define IO_TOP_MSB        15
`define IO_CAP_CODE       4'h1
`define IO_WIN_RESET      4'h0
`define IO_LOW_BOTTOM     12'h000
`define IO_LOW_TOP        12'hFFF
`define ST_PARITY         24
`define ST_SIG_CA         27
`define ST_POISON         31

// event vector layout, shared by status and interrupt registers
`define NUM_EVENTS        6
`define EV_PARITY         0
`define EV_SYS_ERR        4
`define RWC_MASK          6'h31

// control register fields
`define CTRL_PERR_EN      0
`define CTRL_SYS_ERR_EN   1

// axi responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// byte lanes
`define LANE_STATUS_HI    3
`define LANE_IRQ          0
`define LANE_CTRL         0
`define LANE_IO_BOTTOM    0
`define LANE_IO_TOP       1
`define LANE_DS_BUS       1
`define LANE_HB_BUS       2

`endif

// [common/bridge_regs_pkg.sv]
package bridge_regs_pkg;

  // downstream-side events reported by the bridge core, one cycle pulses
  typedef struct packed {
    logic poisoned_tlp;         // poisoned tlp received
    logic system_error_sent;    // err_fatal / err_nonfatal message sent
    logic rx_unsupported;       // completion with unsupported request status
    logic rx_completer_abort;   // completion with completer abort status
    logic sig_completer_abort;  // request completed with completer abort
    logic parity_error;         // parity error detected or forwarded
  } event_t;

  // io request whose address is checked against the window
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } io_request_t;

  // upper address halves from the separate upper-16 registers
  typedef struct packed {
    logic [15:0] limit;
    logic [15:0] base;
  } io_upper_t;

endpackage

// [src/sticky_status_bit.sv]
`timescale 1ns/1ns
`include "bridge_params.svh"

module sticky_status_bit
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clear,
  output logic      q
);
  import bridge_regs_pkg::*;

  // set beats clear in the same cycle so no event is lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= 1'b0;
    else if (ce)
    begin
      if (set)
        q <= 1'b1;
      else if (clear)
        q <= 1'b0;
    end
  end

endmodule

// [src/io_window_match.sv]
`timescale 1ns/1ns
`include "bridge_params.svh"

module io_window_match
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  input  wire bridge_regs_pkg::io_request_t req,
  input  wire bridge_regs_pkg::io_upper_t   upper,
  input  wire logic [3:0]                   bottom_hi,
  input  wire logic [3:0]                   top_hi,
  output logic                              hit_valid,
  output logic                              hit
);
  import bridge_regs_pkg::*;

  // bottom has low twelve bits zero, top has them all ones
  wire [31:0] bottom_addr = {upper.base, bottom_hi, `IO_LOW_BOTTOM};
  wire [31:0] top_addr    = {upper.limit, top_hi, `IO_LOW_TOP};
  wire        in_window   = (req.addr >= bottom_addr) && (req.addr <= top_addr);

  // registered decision, one cycle after the request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hit_valid <= 1'b0;
      hit       <= 1'b0;
    end
    else if (ce)
    begin
      hit_valid <= req.valid;
      hit       <= req.valid & in_window;
    end
  end

endmodule

// [src/bridge_bus_io_window_regs.sv]
`timescale 1ns/1ns
`include "bridge_params.svh"

module bridge_bus_io_window_regs
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  // axi4-lite write address
  input  wire logic [`REG_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  // axi4-lite write data
  input  wire logic [`REG_DATA_W-1:0]       s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // axi4-lite read address
  input  wire logic [`REG_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  // axi4-lite read data
  output logic [`REG_DATA_W-1:0]            s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // bridge core side
  input  wire bridge_regs_pkg::event_t      events,
  input  wire bridge_regs_pkg::io_upper_t   io_upper,
  input  wire bridge_regs_pkg::io_request_t io_request,
  output logic                              io_forward_valid,
  output logic                              io_forward,
  output logic [7:0]                        downstream_bus,
  output logic [7:0]                        highest_bus,
  output logic                              irq
);
  import bridge_regs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [`REG_ADDR_W-1:0]  aw_addr;       // captured write address
  logic                    aw_full;       // write address held
  logic [`REG_DATA_W-1:0]  w_data;        // captured write data
  logic [3:0]              w_strb;        // captured byte enables
  logic                    w_full;        // write data held
  logic [7:0]              ds_bus;        // downstream bus number
  logic [7:0]              hb_bus;        // highest bus below
  logic [3:0]              io_bottom;     // window bottom address 15:12
  logic [3:0]              io_top;        // window top address 15:12
  logic [1:0]              control;       // parity / system error enables
  logic [`NUM_EVENTS-1:0]  irq_enable;    // interrupt enable mask
  logic [`NUM_EVENTS-1:0]  st_bits;       // downstream status sticky bits
  logic [`NUM_EVENTS-1:0]  irq_bits;      // interrupt sticky bits
  logic [`REG_DATA_W-1:0]  next_rdata;    // read mux result
  logic [1:0]              next_rresp;    // read response for the mux

  //////////////////////////////////////////////////////////////////////////////
  // write channel decode
  // both halves of a write present and no response outstanding
  wire do_write = aw_full & w_full & ~s_axi_bvalid;

  // word-aligned write address
  wire [`REG_ADDR_W-1:0] wr_word = {aw_addr[`REG_ADDR_W-1:2], 2'h0};

  wire sel_w_bus     = (wr_word == `OFS_BUS_NUMBERS);
  wire sel_w_io      = (wr_word == `OFS_IO_STATUS);
  wire sel_w_ctrl    = (wr_word == `OFS_CONTROL);
  wire sel_w_irq_st  = (wr_word == `OFS_IRQ_STATUS);
  wire sel_w_irq_clr = (wr_word == `OFS_IRQ_CLEAR);
  wire sel_w_irq_en  = (wr_word == `OFS_IRQ_ENABLE);
  wire w_mapped      = sel_w_bus | sel_w_io | sel_w_ctrl | sel_w_irq_st
                     | sel_w_irq_clr | sel_w_irq_en;

  // per-register write strobes
  wire wr_bus     = do_write & sel_w_bus;
  wire wr_io      = do_write & sel_w_io;
  wire wr_ctrl    = do_write & sel_w_ctrl;
  wire wr_irq_clr = do_write & sel_w_irq_clr;
  wire wr_irq_en  = do_write & sel_w_irq_en;

  // accept each channel while its holding slot is empty
  assign s_axi_awready = ~aw_full;
  assign s_axi_wready  = ~w_full;

  //////////////////////////////////////////////////////////////////////////////
  // write address and data capture, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
        aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
        w_full <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        // unmapped words answer slverr, read-only words are silently ok
        s_axi_bresp  <= w_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus number dword
  // each bus number byte follows its own enable; latency and primary bytes have no storage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ds_bus <= `BUS_NUM_RESET;
      hb_bus <= `BUS_NUM_RESET;
    end
    else if (ce && wr_bus)
    begin
      if (w_strb[`LANE_DS_BUS])
        ds_bus <= w_data[`DS_BUS_MSB:`DS_BUS_LSB];
      if (w_strb[`LANE_HB_BUS])
        hb_bus <= w_data[`HB_BUS_MSB:`HB_BUS_LSB];
    end
  end

  assign downstream_bus = ds_bus;
  assign highest_bus    = hb_bus;

  //////////////////////////////////////////////////////////////////////////////
  // io window nibbles
  // only the address nibbles store; capability nibbles are constants
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      io_bottom <= `IO_WIN_RESET;
      io_top    <= `IO_WIN_RESET;
    end
    else if (ce && wr_io)
    begin
      if (w_strb[`LANE_IO_BOTTOM])
        io_bottom <= w_data[`IO_BOT_MSB:`IO_BOT_LSB];
      if (w_strb[`LANE_IO_TOP])
        io_top    <= w_data[`IO_TOP_MSB:`IO_TOP_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control and interrupt enable registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control    <= '0;
      irq_enable <= '0;
    end
    else if (ce)
    begin
      if (wr_ctrl && w_strb[`LANE_CTRL])
        control    <= w_data[1:0];
      if (wr_irq_en && w_strb[`LANE_IRQ])
        irq_enable <= w_data[`NUM_EVENTS-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event gating and sticky bits
  wire [`NUM_EVENTS-1:0] ev_raw = events;

  // parity and system error events qualified by their enables
  wire [`NUM_EVENTS-1:0] ev_gate;
  assign ev_gate[`EV_PARITY]  = control[`CTRL_PERR_EN];
  assign ev_gate[3:1]         = '1;
  assign ev_gate[`EV_SYS_ERR] = control[`CTRL_SYS_ERR_EN];
  assign ev_gate[5]           = 1'b1;
  wire [`NUM_EVENTS-1:0] ev_set = ev_raw & ev_gate;

  // status bits as seen in the upper half of the dword
  wire [`NUM_EVENTS-1:0] st_wr_field =
    {w_data[`ST_POISON:`ST_SIG_CA], w_data[`ST_PARITY]};

  // write one clears, only for the rwc bits and only with lane 3 enabled
  wire [`NUM_EVENTS-1:0] st_clear =
    {`NUM_EVENTS{wr_io & w_strb[`LANE_STATUS_HI]}} & st_wr_field & `RWC_MASK;

  // interrupt clear register, write one to clear
  wire [`NUM_EVENTS-1:0] irq_clear =
    {`NUM_EVENTS{wr_irq_clr & w_strb[`LANE_IRQ]}} & w_data[`NUM_EVENTS-1:0];

  // one status bit and one interrupt bit per event
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_EVENTS; gi = gi + 1)
    begin : g_events
      sticky_status_bit u_status
      (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .set     (ev_set[gi]),
        .clear   (st_clear[gi]),
        .q       (st_bits[gi])
      );
      sticky_status_bit u_irq
      (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .set     (ev_set[gi]),
        .clear   (irq_clear[gi]),
        .q       (irq_bits[gi])
      );
    end
  endgenerate

  // level interrupt while any enabled bit is pending
  assign irq = |(irq_bits & irq_enable);

  //////////////////////////////////////////////////////////////////////////////
  // read data assembly
  // 18h: latency byte constant, two bus numbers, primary byte outside
  wire [`REG_DATA_W-1:0] rd_bus_numbers =
    {`LATENCY_VALUE, hb_bus, ds_bus, 8'h00};

  // status upper half: reserved and legacy bits constant zero
  wire [15:0] rd_status =
    {st_bits[5:1], 2'h0, st_bits[`EV_PARITY], 8'h00};

  // 1ch: status, top nibble with capability code, bottom likewise
  wire [`REG_DATA_W-1:0] rd_io_status =
    {rd_status, io_top, `IO_CAP_CODE, io_bottom, `IO_CAP_CODE};

  wire [`REG_DATA_W-1:0] rd_control    = {30'h0, control};
  wire [`REG_DATA_W-1:0] rd_irq_status = {26'h0, irq_bits};
  wire [`REG_DATA_W-1:0] rd_irq_enable = {26'h0, irq_enable};

  // word-aligned read address
  wire [`REG_ADDR_W-1:0] rd_word = {s_axi_araddr[`REG_ADDR_W-1:2], 2'h0};

  // read selection; clear register is write-only and reads zero
  always_comb
  begin
    next_rresp = `RESP_OKAY;
    case (rd_word)
      `OFS_BUS_NUMBERS: next_rdata = rd_bus_numbers;
      `OFS_IO_STATUS:   next_rdata = rd_io_status;
      `OFS_CONTROL:     next_rdata = rd_control;
      `OFS_IRQ_STATUS:  next_rdata = rd_irq_status;
      `OFS_IRQ_CLEAR:   next_rdata = '0;
      `OFS_IRQ_ENABLE:  next_rdata = rd_irq_enable;
      default:
      begin
        next_rdata = '0;
        next_rresp = `RESP_SLVERR;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // read channel
  // one read at a time; address accepted while no data is waiting
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rresp;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // io window forwarding decision
  io_window_match u_window
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .req       (io_request),
    .upper     (io_upper),
    .bottom_hi (io_bottom),
    .top_hi    (io_top),
    .hit_valid (io_forward_valid),
    .hit       (io_forward)
  );

endmodule

// [tb/io_core_model.sv]
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// bridge core stand-in: event pulses, io requests, upper window halves
module io_core_model
(
  input  wire logic                  aclk,
  output bridge_regs_pkg::event_t     events,
  output bridge_regs_pkg::io_upper_t  io_upper,
  output bridge_regs_pkg::io_request_t io_request
);
  import bridge_regs_pkg::*;

  // quiet lines at time zero
  initial
  begin
    events = '0;
    io_upper = '0;
    io_request = '0;
  end

  // upper address halves come from their own registers, held as a level
  task automatic set_upper(input io_upper_t u);
    @(posedge aclk);
    io_upper <= u;
  endtask

  // one-cycle request; address is scrambled once released
  task automatic send_io(input logic [31:0] a);
    @(posedge aclk);
    io_request <= {1'b1, a};
    @(posedge aclk);
    io_request <= {1'b0, ~a};
  endtask

  // one-cycle event pulse
  task automatic pulse(input event_t e);
    @(posedge aclk);
    events <= e;
    @(posedge aclk);
    events <= '0;
  endtask
endmodule

// [tb/bridge_regs_chk.sv]
`timescale 1ns/1ns
`include "bridge_params.svh"

////////////////////////////////////////////////////////////////////////////////
// port-level checker for the bus number / io window registers
module bridge_regs_chk
(
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  input  wire logic [`REG_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  input  wire logic                         s_axi_awready,
  input  wire logic [1:0]                   s_axi_bresp,
  input  wire logic                         s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [`REG_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  input  wire logic                         s_axi_arready,
  input  wire logic [`REG_DATA_W-1:0]       s_axi_rdata,
  input  wire logic [1:0]                   s_axi_rresp,
  input  wire logic                         s_axi_rvalid,
  input  wire bridge_regs_pkg::io_request_t io_request,
  input  wire logic                         io_forward_valid,
  input  wire logic                         io_forward,
  input  wire logic [7:0]                   downstream_bus,
  input  wire logic [7:0]                   highest_bus,
  input  wire logic                         irq
);
  import bridge_regs_pkg::*;

  logic [7:0] rd_addr;   // word address of the read in flight
  logic [7:0] wr_addr;   // word address of the last write taken
  wire  logic rd_map = rd_addr inside {`OFS_BUS_NUMBERS, `OFS_IO_STATUS, `OFS_CONTROL,
                                       `OFS_IRQ_STATUS, `OFS_IRQ_CLEAR, `OFS_IRQ_ENABLE};
  wire  logic wr_map = wr_addr inside {`OFS_BUS_NUMBERS, `OFS_IO_STATUS, `OFS_CONTROL,
                                       `OFS_IRQ_STATUS, `OFS_IRQ_CLEAR, `OFS_IRQ_ENABLE};
  wire  logic rd_bus = s_axi_rvalid && rd_addr == `OFS_BUS_NUMBERS;
  wire  logic rd_io  = s_axi_rvalid && rd_addr == `OFS_IO_STATUS;

  // remember addresses at their handshakes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_addr <= '0;
      wr_addr <= '0;
    end
    else
    begin
      if (ce && s_axi_arvalid && s_axi_arready)
        rd_addr <= {s_axi_araddr[7:2], 2'b00};
      if (ce && s_axi_awvalid && s_axi_awready)
        wr_addr <= {s_axi_awaddr[7:2], 2'b00};
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  property p_latency; rd_bus |-> s_axi_rdata[31:24] == `LATENCY_VALUE; endproperty
  a_latency: assert property (p_latency) else $error("latency byte not zero");
  property p_ds_bus; rd_bus |-> s_axi_rdata[15:8] == downstream_bus; endproperty
  a_ds_bus: assert property (p_ds_bus) else $error("bus number read mismatch");
  property p_hb_bus; rd_bus |-> s_axi_rdata[23:16] == highest_bus; endproperty
  a_hb_bus: assert property (p_hb_bus) else $error("highest bus read mismatch");
  property p_cap;
    rd_io |-> s_axi_rdata[3:0] == `IO_CAP_CODE && s_axi_rdata[11:8] == `IO_CAP_CODE;
  endproperty
  a_cap: assert property (p_cap) else $error("io capability code wrong");
  property p_zero; rd_io |-> (s_axi_rdata[26:16] & 11'h6FF) == 11'h000; endproperty
  a_zero: assert property (p_zero) else $error("fixed status bits not zero");
  property p_fwd_time; ce && io_request.valid |=> io_forward_valid; endproperty
  a_fwd_time: assert property (p_fwd_time) else $error("no forward answer");
  property p_fwd_idle; ce && !io_request.valid |=> !io_forward_valid && !io_forward; endproperty
  a_fwd_idle: assert property (p_fwd_idle) else $error("forward without request");
  property p_bresp; $rose(s_axi_bvalid) |-> s_axi_bresp == (wr_map ? `RESP_OKAY : `RESP_SLVERR);
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response wrong");
  property p_rresp; $rose(s_axi_rvalid) |-> s_axi_rresp == (rd_map ? `RESP_OKAY : `RESP_SLVERR);
  endproperty
  a_rresp: assert property (p_rresp) else $error("read response wrong");

  // main scenarios reached
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_io_read: cover property (rd_io);
  c_hit: cover property (io_forward);
  c_irq: cover property (irq);
endmodule

bind bridge_bus_io_window_regs bridge_regs_chk bridge_regs_chk_inst
(
  .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .io_request, .io_forward_valid, .io_forward, .downstream_bus,
  .highest_bus, .irq
);

// [tb/testbench.sv]
`timescale 1ns/1ns
`include "bridge_params.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end

////////////////////////////////////////////////////////////////////////////////
module testbench;
  import bridge_regs_pkg::*;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic io_forward_valid, io_forward, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, downstream_bus, highest_bus;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdata_s;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_s, rresp_s;
  logic        hs_aw, hs_w, hs_b, hs_ar, hs_r;   // handshakes seen before the next edge
  event_t      events;
  io_upper_t   io_upper;
  io_request_t io_request;
  int          bad_count, cmp_count, cycle_count;
  logic [31:0] io_addr [5] = '{32'h00013000, 32'h00012FFF, 32'h0001AFFF, 32'h0001B000,
                               32'h00023000};
  logic        io_hit [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  bridge_bus_io_window_regs bridge_bus_io_window_regs_inst (.*);
  io_core_model io_core_model_inst (.aclk, .events, .io_upper, .io_request);

  // clock, 20 ns period
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // sample bus state mid-cycle; inputs move only at rising edges
  always @(negedge aclk)
  begin
    hs_aw = s_axi_awvalid & s_axi_awready;
    hs_w = s_axi_wvalid & s_axi_wready;
    hs_b = s_axi_bvalid & s_axi_bready;
    hs_ar = s_axi_arvalid & s_axi_arready;
    hs_r = s_axi_rvalid & s_axi_rready;
    bresp_s = s_axi_bresp;
    rresp_s = s_axi_rresp;
    rdata_s = s_axi_rdata;
  end

  // hang guard
  always @(posedge aclk)
  begin
    cycle_count++;
    if (cycle_count == 3000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (hs_aw) s_axi_awvalid <= 1'b0;
      if (hs_w) s_axi_wvalid <= 1'b0;
      done = hs_b;
    end
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, bresp_s)
  endtask

  // axi4-lite read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (hs_ar) s_axi_arvalid <= 1'b0;
      done = hs_r;
    end
    s_axi_rready <= 1'b0;
    `CHK("rdata", e, rdata_s)
    `CHK("rresp", er, rresp_s)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    ce = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, then read-only and byte-lane behaviour
    rd(`OFS_BUS_NUMBERS, 32'h00000000, `RESP_OKAY);
    rd(`OFS_IO_STATUS, 32'h00000101, `RESP_OKAY);
    wr(`OFS_BUS_NUMBERS, 32'hFFFFFFFF, 4'hF, `RESP_OKAY);
    rd(`OFS_BUS_NUMBERS, 32'h00FFFF00, `RESP_OKAY);
    `CHK("downstream_bus", 8'hFF, downstream_bus)
    wr(`OFS_BUS_NUMBERS, 32'h12345678, 4'h2, `RESP_OKAY);
    rd(`OFS_BUS_NUMBERS, 32'h00FF5600, `RESP_OKAY);
    `CHK("highest_bus", 8'hFF, highest_bus)
    wr(`OFS_IO_STATUS, 32'hFFFFFF35, 4'h1, `RESP_OKAY);
    wr(`OFS_IO_STATUS, 32'h0000A000, 4'h2, `RESP_OKAY);
    rd(`OFS_IO_STATUS, 32'h0000A131, `RESP_OKAY);
    // window 0001_3000 .. 0001_AFFF, edges and a wrong upper half
    io_core_model_inst.set_upper({16'h0001, 16'h0001});
    for (int i = 0; i < 5; i++)
    begin
      io_core_model_inst.send_io(io_addr[i]);
      #1;
      `CHK("forward_valid", 1'b1, io_forward_valid)
      `CHK("forward", io_hit[i], io_forward)
    end
    // parity and system error blocked while their enables are off
    io_core_model_inst.pulse(event_t'(6'h11));
    rd(`OFS_IO_STATUS, 32'h0000A131, `RESP_OKAY);
    io_core_model_inst.pulse(event_t'(6'h2E));
    wr(`OFS_CONTROL, 32'h00000003, 4'h1, `RESP_OKAY);
    io_core_model_inst.pulse(event_t'(6'h11));
    rd(`OFS_IO_STATUS, 32'hF900A131, `RESP_OKAY);
    wr(`OFS_IO_STATUS, 32'h00000000, 4'h8, `RESP_OKAY);
    rd(`OFS_IO_STATUS, 32'hF900A131, `RESP_OKAY);
    wr(`OFS_IO_STATUS, 32'hFF000000, 4'h8, `RESP_OKAY);
    rd(`OFS_IO_STATUS, 32'h3800A131, `RESP_OKAY);
    // clock enable low: an enabled parity event must not be taken
    ce <= 1'b0;
    io_core_model_inst.pulse(event_t'(6'h01));
    ce <= 1'b1;
    rd(`OFS_IO_STATUS, 32'h3800A131, `RESP_OKAY);
    // interrupt: masked, enabled, cleared
    `CHK("irq", 1'b0, irq)
    rd(`OFS_IRQ_STATUS, 32'h0000003F, `RESP_OKAY);
    wr(`OFS_IRQ_ENABLE, 32'h00000001, 4'h1, `RESP_OKAY);
    `CHK("irq", 1'b1, irq)
    wr(`OFS_IRQ_CLEAR, 32'h00000001, 4'h1, `RESP_OKAY);
    `CHK("irq", 1'b0, irq)
    rd(`OFS_IRQ_STATUS, 32'h0000003E, `RESP_OKAY);
    rd(`OFS_IRQ_CLEAR, 32'h00000000, `RESP_OKAY);
    // unmapped places
    rd(8'h10, 32'h00000000, `RESP_SLVERR);
    wr(8'h30, 32'hFFFFFFFF, 4'hF, `RESP_SLVERR);
    give_verdict();
  end
endmodule
